//--- shared/rcm_map.vh
// Purpose: Register map and constants of the reference limit monitor
// Assumes: 8-bit register bus, byte addresses
// Notes:   Included by rtl/rcm_ref_limit_monitor.v
`ifndef RCM_MAP_VH
`define RCM_MAP_VH

// Register offsets
`define RCM_LIMIT_A_ADDR 8'h4B
`define RCM_LIMIT_B_ADDR 8'h4C
`define RCM_NOM_A_LO_ADDR 8'h60
`define RCM_NOM_A_HI_ADDR 8'h61
`define RCM_NOM_B_LO_ADDR 8'h62
`define RCM_NOM_B_HI_ADDR 8'h63
`define RCM_STATUS_ADDR 8'h64
`define RCM_MASK_ADDR 8'h65
`define RCM_LIVE_ADDR 8'h66

// Reset values
`define RCM_LIMIT_RST 8'h55
`define RCM_NOM_RST 16'h0000
`define RCM_STATUS_RST 4'h0
`define RCM_MASK_RST 4'h0

// Field positions in a limit register
`define RCM_COARSE_MSB 2
`define RCM_COARSE_LSB 0
`define RCM_PERIOD_MSB 6
`define RCM_PERIOD_LSB 4
`define RCM_LIMIT_KEEP 8'h77

// Status, mask and live bit positions
`define RCM_BIT_A_COARSE 0
`define RCM_BIT_A_PERIOD 1
`define RCM_BIT_B_COARSE 2
`define RCM_BIT_B_PERIOD 3

// Tolerance ladder in parts per thousand
`define RCM_TOL_0 10'h001
`define RCM_TOL_1 10'h005
`define RCM_TOL_2 10'h00A
`define RCM_TOL_3 10'h014
`define RCM_TOL_4 10'h032
`define RCM_TOL_5 10'h064
`define RCM_TOL_6 10'h0C8
`define RCM_TOL_7 10'h1F4
`define RCM_PER_MILLE 40'h00000003E8

// Sample tick and coarse averaging length
`define RCM_SAMPLE_PS 1250
`define RCM_AVG_PERIODS 5'h10
`define RCM_AVG_SHIFT 4

`endif

//--- rtl/rcm_ref_limit_monitor.v
// Purpose: Coarse and single-cycle frequency monitors for two references
// Assumes: Reference inputs synchronous to clk_sys; one clk_sys cycle is
//          one sample tick of the period measurement
// Notes:   Nominal periods, sticky status, mask and a live view sit at
//          offsets of their own; a nominal period of zero turns that
//          reference's monitors off and clears their indicators.
//          A first rising edge only arms a monitor; late checks start right
//          after it, the period edge check at the second edge, the coarse one at the 17th. Summary of operation follows.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "rcm_map.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// One reference monitor: period and averaged frequency checks.
// Both checks share one rise detector and one tick counter, so the
// averaged check costs only an accumulator and a period counter.
module rcm_ref_mon #(
  parameter PERIOD_W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Reference and settings
  input wire refIn,
  input wire [PERIOD_W-1:0] nomPeriod,
  input wire [2:0] coarseCode,
  input wire [2:0] periodCode,
  // Failure indicators
  output reg coarseFail,
  output reg periodFail
);

  // Accumulator holds a full window of periods plus headroom
  localparam SUM_W = PERIOD_W + 5;

  // Tolerance code to parts per thousand
  // One ladder serves both checks and both references
  function [9:0] tolK;
    input [2:0] code;
    begin
      case (code)
        3'h0: tolK = `RCM_TOL_0;
        3'h1: tolK = `RCM_TOL_1;
        3'h2: tolK = `RCM_TOL_2;
        3'h3: tolK = `RCM_TOL_3;
        3'h4: tolK = `RCM_TOL_4;
        3'h5: tolK = `RCM_TOL_5;
        3'h6: tolK = `RCM_TOL_6;
        default: tolK = `RCM_TOL_7;
      endcase
    end
  endfunction

  // Edge detector, tick counter and averaging state
  reg refPrev;
  reg armed;
  reg [PERIOD_W-1:0] cnt;
  reg [SUM_W-1:0] sum;
  reg [4:0] edgeCnt;
  // Measurement arithmetic; 40 bits keep every product from wrapping
  wire rise;
  wire cntFull;
  wire [39:0] nom40;
  wire [39:0] kP;
  wire [39:0] kC;
  wire [39:0] pMeas;
  wire [39:0] pDiff;
  wire [39:0] cMeas;
  wire [39:0] cNom;
  wire [39:0] cDiff;
  wire periodBad;
  wire coarseBad;
  wire periodLate;
  wire coarseLate;
  wire lastOfAvg;

  // Rise: reference high now after a low sample
  assign rise = refIn & ~refPrev;
  // The tick counter stops at all ones, so a dead reference cannot wrap
  assign cntFull = &cnt;
  assign nom40 = {{(40-PERIOD_W){1'b0}}, nomPeriod};
  // Tolerances in parts per thousand
  assign kP = {30'h0, tolK(periodCode)};
  assign kC = {30'h0, tolK(coarseCode)};
  // Period just ended, in sample ticks; the count is 0 in the tick after
  // a rise, so the rise-to-rise distance is the count plus one
  assign pMeas = {{(40-PERIOD_W){1'b0}}, cnt} + 40'h1;
  assign pDiff = (pMeas > nom40) ? pMeas - nom40 : nom40 - pMeas;
  // Scaled compare, |P-N|*1000 against N*k, needs no divider
  assign periodBad = pDiff * `RCM_PER_MILLE > nom40 * kP;
  // Average over a block of periods, compared as a total
  assign cMeas = {{(40-SUM_W){1'b0}}, sum} + pMeas;
  assign cNom = nom40 << `RCM_AVG_SHIFT;
  assign cDiff = (cMeas > cNom) ? cMeas - cNom : cNom - cMeas;
  assign coarseBad = cDiff * `RCM_PER_MILLE > cNom * kC;
  // Missing edge: running count already beyond the upper bound, so a
  // stopped reference fails without waiting for an edge that never comes
  assign periodLate = pMeas * `RCM_PER_MILLE >
    nom40 * (`RCM_PER_MILLE + kP);
  assign coarseLate = cMeas * `RCM_PER_MILLE >
    cNom * (`RCM_PER_MILLE + kC);
  assign lastOfAvg = (edgeCnt == `RCM_AVG_PERIODS - 5'h1);

  // Edge tracking, tick counter and averaging accumulator.
  // A zero nominal period holds everything idle, so a setting written
  // after zero starts with a fresh arming edge and an empty window.
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      refPrev <= 1'b0;
      armed <= 1'b0;
      cnt <= {PERIOD_W{1'b0}};
      sum <= {SUM_W{1'b0}};
      edgeCnt <= 5'h0;
    end else begin
      refPrev <= refIn;
      if (nomPeriod == {PERIOD_W{1'b0}}) begin
        armed <= 1'b0;
        cnt <= {PERIOD_W{1'b0}};
        sum <= {SUM_W{1'b0}};
        edgeCnt <= 5'h0;
      end else if (rise) begin
        // First rise only arms; later rises close a period, and every
        // 16th closed period ends an averaging window
        armed <= 1'b1;
        cnt <= {PERIOD_W{1'b0}};
        if (!armed || lastOfAvg) begin
          sum <= {SUM_W{1'b0}};
          edgeCnt <= 5'h0;
        end else begin
          sum <= cMeas[SUM_W-1:0];
          edgeCnt <= edgeCnt + 5'h1;
        end
      end else if (!cntFull) begin
        cnt <= cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Failure indicators, updated at each completed measurement.
  // A late check raises an indicator between edges; the next rise re-evaluates
  // periodFail and the next window close coarseFail, so a reference that recovers clears it again.
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      periodFail <= 1'b0;
      coarseFail <= 1'b0;
    end else if (nomPeriod == {PERIOD_W{1'b0}}) begin
      periodFail <= 1'b0;
      coarseFail <= 1'b0;
    end else if (armed) begin
      if (rise) begin
        periodFail <= periodBad;
      end else if (periodLate) begin
        periodFail <= 1'b1;
      end
      // Coarse result is taken only when a window closes
      if (rise && lastOfAvg) begin
        coarseFail <= coarseBad;
      end else if (coarseLate) begin
        coarseFail <= 1'b1;
      end
    end
  end

endmodule // rcm_ref_mon

////////////////////////////////////////////////////////////////////////////
// Top: limit registers, nominal periods, status, mask and interrupt.
// Status bits set on a rising live indicator, so a fault that persists
// raises the interrupt once until software clears the bit.
module rcm_ref_limit_monitor #(
  parameter PERIOD_W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  // References under watch
  input wire referenceInputA,
  input wire referenceInputB,
  // Failure indicators and interrupt
  output wire [3:0] failLive,
  output wire irq
);

  // Reset release
  reg rstSync1;
  reg rstSync2;
  wire rstN;
  // Software visible registers
  reg [7:0] limitA_reg;
  reg [7:0] limitB_reg;
  reg [15:0] nomA_reg;
  reg [15:0] nomB_reg;
  reg [3:0] status_reg;
  reg [3:0] mask_reg;
  // Rise detection of the live indicators and the read path
  reg [3:0] liveDly_reg;
  reg [7:0] rdData_next;
  wire [3:0] live;
  wire [3:0] liveRise;
  wire [3:0] w1c;
  // Tolerance fields of the two limit registers
  wire [2:0] inputACoarseTolerance;
  wire [2:0] inputAPeriodTolerance;
  wire [2:0] inputBCoarseTolerance;
  wire [2:0] inputBPeriodTolerance;

  // Reset release through two flops, so no flop leaves reset mid-edge
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rstN = rstSync2;

  // Tolerance fields; bits 3 and 7 feed nothing
  assign inputACoarseTolerance =
    limitA_reg[`RCM_COARSE_MSB:`RCM_COARSE_LSB];
  assign inputAPeriodTolerance =
    limitA_reg[`RCM_PERIOD_MSB:`RCM_PERIOD_LSB];
  assign inputBCoarseTolerance =
    limitB_reg[`RCM_COARSE_MSB:`RCM_COARSE_LSB];
  assign inputBPeriodTolerance =
    limitB_reg[`RCM_PERIOD_MSB:`RCM_PERIOD_LSB];

  // Monitor for input A
  // Its indicators land in bits 0 and 1 of the live view
  rcm_ref_mon #(.PERIOD_W(PERIOD_W)) monA (
    .clk(clk_sys),
    .rstN(rstN),
    .refIn(referenceInputA),
    .nomPeriod(nomA_reg[PERIOD_W-1:0]),
    .coarseCode(inputACoarseTolerance),
    .periodCode(inputAPeriodTolerance),
    .coarseFail(live[`RCM_BIT_A_COARSE]),
    .periodFail(live[`RCM_BIT_A_PERIOD])
  );

  // Monitor for input B
  // Its indicators land in bits 2 and 3 of the live view
  rcm_ref_mon #(.PERIOD_W(PERIOD_W)) monB (
    .clk(clk_sys),
    .rstN(rstN),
    .refIn(referenceInputB),
    .nomPeriod(nomB_reg[PERIOD_W-1:0]),
    .coarseCode(inputBCoarseTolerance),
    .periodCode(inputBPeriodTolerance),
    .coarseFail(live[`RCM_BIT_B_COARSE]),
    .periodFail(live[`RCM_BIT_B_PERIOD])
  );

  // Live indicators and their rising edges
  assign failLive = live;
  assign liveRise = live & ~liveDly_reg;
  // Write-one-to-clear bits from a status write
  assign w1c = (regWr && regAddr == `RCM_STATUS_ADDR) ?
    regWrData[3:0] : 4'h0;
  // Level interrupt while any unmasked status bit stands
  assign irq = |(status_reg & mask_reg);

  // Register writes; sticky status with set winning over clear
  // A clear and a new rise in one cycle leave the bit set
  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      limitA_reg <= `RCM_LIMIT_RST;
      limitB_reg <= `RCM_LIMIT_RST;
      nomA_reg <= `RCM_NOM_RST;
      nomB_reg <= `RCM_NOM_RST;
      status_reg <= `RCM_STATUS_RST;
      mask_reg <= `RCM_MASK_RST;
      liveDly_reg <= 4'h0;
    end else begin
      liveDly_reg <= live;
      status_reg <= (status_reg & ~w1c) | liveRise;
      if (regWr) begin
        case (regAddr)
          // Limits keep all eight bits; only the fields feed a monitor
          `RCM_LIMIT_A_ADDR: limitA_reg <= regWrData;
          `RCM_LIMIT_B_ADDR: limitB_reg <= regWrData;
          `RCM_NOM_A_LO_ADDR: nomA_reg[7:0] <= regWrData;
          `RCM_NOM_A_HI_ADDR: nomA_reg[15:8] <= regWrData;
          `RCM_NOM_B_LO_ADDR: nomB_reg[7:0] <= regWrData;
          `RCM_NOM_B_HI_ADDR: nomB_reg[15:8] <= regWrData;
          `RCM_MASK_ADDR: mask_reg <= regWrData[3:0];
          default: mask_reg <= mask_reg;
        endcase
      end
    end
  end

  // Read mux
  // Unmapped addresses read as zero
  always @* begin
    case (regAddr)
      `RCM_LIMIT_A_ADDR: rdData_next = limitA_reg;
      `RCM_LIMIT_B_ADDR: rdData_next = limitB_reg;
      `RCM_NOM_A_LO_ADDR: rdData_next = nomA_reg[7:0];
      `RCM_NOM_A_HI_ADDR: rdData_next = nomA_reg[15:8];
      `RCM_NOM_B_LO_ADDR: rdData_next = nomB_reg[7:0];
      `RCM_NOM_B_HI_ADDR: rdData_next = nomB_reg[15:8];
      `RCM_STATUS_ADDR: rdData_next = {4'h0, status_reg};
      `RCM_MASK_ADDR: rdData_next = {4'h0, mask_reg};
      `RCM_LIVE_ADDR: rdData_next = {4'h0, live};
      default: rdData_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero otherwise, so a stale value is never taken for an answer
  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdData_next;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // rcm_ref_limit_monitor

`default_nettype wire

//--- dv/rcm_check_monitor.sv
// Purpose: Port checker of the reference limit monitor
// Assumes: Bound to rcm_ref_limit_monitor, one clock
// Notes: Shadows track register writes
`timescale 1ns/10ps
`include "rcm_map.vh"
`default_nettype none
module rcm_check (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // References and indicators
  input wire logic referenceInputA,
  input wire logic referenceInputB,
  input wire logic [3:0] failLive,
  input wire logic irq
);
  logic [7:0] limA_reg, limB_reg, nomALo_reg, nomAHi_reg;
  logic [7:0] nomBLo_reg, nomBHi_reg;
  logic [3:0] mask_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the writable registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      limA_reg <= `RCM_LIMIT_RST;
      limB_reg <= `RCM_LIMIT_RST;
      {nomALo_reg, nomAHi_reg, nomBLo_reg, nomBHi_reg, mask_reg} <= 36'h0;
    end else if (regWr) begin
      case (regAddr)
        `RCM_LIMIT_A_ADDR: limA_reg <= regWrData;
        `RCM_LIMIT_B_ADDR: limB_reg <= regWrData;
        `RCM_NOM_A_LO_ADDR: nomALo_reg <= regWrData;
        `RCM_NOM_A_HI_ADDR: nomAHi_reg <= regWrData;
        `RCM_NOM_B_LO_ADDR: nomBLo_reg <= regWrData;
        `RCM_NOM_B_HI_ADDR: nomBHi_reg <= regWrData;
        `RCM_MASK_ADDR: mask_reg <= regWrData[3:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not idle");
  a_rd_limit_a: assert property (
    regRd && regAddr == `RCM_LIMIT_A_ADDR |=> regRdData == $past(limA_reg))
    else $error("limit A readback wrong");
  a_rd_limit_b: assert property (
    regRd && regAddr == `RCM_LIMIT_B_ADDR |=> regRdData == $past(limB_reg))
    else $error("limit B readback wrong");
  a_rd_unmapped: assert property (regRd && regAddr > `RCM_LIVE_ADDR |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
  a_rd_mask: assert property (regRd && regAddr == `RCM_MASK_ADDR |=>
    regRdData == {4'h0, $past(mask_reg)}) else $error("mask readback");
  a_rd_live: assert property (regRd && regAddr == `RCM_LIVE_ADDR |=>
    regRdData == {4'h0, $past(failLive)}) else $error("live readback");
  a_irq_masked: assert property (mask_reg == 4'h0 &&
    $past(mask_reg) == 4'h0 |-> !irq) else $error("irq while masked");
  a_nom_off_a: assert property ({nomAHi_reg, nomALo_reg} == 16'h0 [*4]
    |-> failLive[1:0] == 2'b00) else $error("A monitor not disabled");
  a_nom_off_b: assert property ({nomBHi_reg, nomBLo_reg} == 16'h0 [*4]
    |-> failLive[3:2] == 2'b00) else $error("B monitor not disabled");
  c_irq: cover property ($rose(irq));
  c_a_late: cover property ($rose(failLive[0]));
  c_b_fail: cover property ($rose(failLive[3]));
  c_unmapped: cover property (regRd && regAddr == 8'h70);
endmodule // rcm_check
bind rcm_ref_limit_monitor rcm_check u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .referenceInputA(referenceInputA),
  .referenceInputB(referenceInputB), .failLive(failLive), .irq(irq));
`default_nettype wire

//--- dv/rcm_ref_model.sv
// Purpose: Two reference sources with set periods
// Assumes: Periods in clk_sys ticks; 0 stops the source low
// Notes: A new period applies from the current count on
`timescale 1ns/10ps
`default_nettype none
module rcm_ref_model (
  // Clock and periods
  input wire logic clk,
  input wire logic [15:0] perA,
  input wire logic [15:0] perB,
  // References
  output logic refA,
  output logic refB
);
  logic [15:0] cntA = 16'h0000;
  logic [15:0] cntB = 16'h0000;
  // Period counters, one rise per period
  always @(posedge clk) begin
    cntA <= (cntA + 1 >= perA) ? 16'h0000 : cntA + 16'h0001;
    cntB <= (cntB + 1 >= perB) ? 16'h0000 : cntB + 16'h0001;
  end
  assign refA = cntA < perA / 2;
  assign refB = cntB < perB / 2;
endmodule // rcm_ref_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench of the reference limit monitor
// Assumes: Register reads checked by a queue watcher
// Notes: Periods kept short so each tolerance step settles fast
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, lim;
  logic regWr = 1'b0, regRd = 1'b0, rdD = 1'b0, refA, refB, irq;
  logic [3:0] failLive;
  logic [15:0] perA = 16'h0025, perB = 16'h0025;
  logic [7:0] expQ[$];
  int n_mismatch = 0, n_tests = 0, cyc = 0, n, d;
  int tol[8] = '{1, 5, 10, 20, 50, 100, 200, 500};
  rcm_ref_limit_monitor i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .referenceInputA(refA), .referenceInputB(refB),
    .failLive(failLive), .irq(irq));
  rcm_ref_model i_ref (.clk(clk_sys), .perA(perA), .perB(perB),
    .refA(refA), .refB(refB));
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask
  // Long enough for two coarse windows at the longest period used
  task automatic settle(input logic [7:0] e);
    repeat (3600) @(posedge clk_sys);
    @(negedge clk_sys);
    check("irq", {7'h00, irq}, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Read data watcher and run limit
  always @(posedge clk_sys) begin
    rdD <= regRd;
    if (rdD) check("rdata", regRdData, expQ.pop_front());
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(62));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h4B, 8'h55);
    rd(8'h4C, 8'h55);
    for (logic [7:0] a = 8'h60; a < 8'h67; a++) rd(a, 8'h00);
    rd(8'h70, 8'h00);
    lim = 8'($urandom) & 8'h77;
    wr(8'h4B, lim);
    rd(8'h4B, lim);
    wr(8'h4C, ~lim & 8'h77);
    rd(8'h4C, ~lim & 8'h77);
    @(negedge clk_sys);
    check("live", {4'h0, failLive}, 8'h00);
    $display("test registers done");
    // Every code: A just inside, B just outside; reserved bits random
    for (int c = 0; c < 8; c++) begin
      n = 30 + $urandom % 30;
      d = n * tol[c] / 1000;
      lim = {1'($urandom), 3'(c), 1'($urandom), 3'(c)};
      wr(8'h4B, lim);
      wr(8'h4C, lim);
      wr(8'h60, 8'(n));
      wr(8'h61, 8'h00);
      wr(8'h62, 8'(n));
      wr(8'h63, 8'h00);
      perA <= 16'(n + d);
      perB <= 16'(n + d + 1);
      settle(8'h00);
      check("live", {4'h0, failLive}, 8'h0C);
      rd(8'h66, 8'h0C);
    end
    $display("test tolerances done");
    wr(8'h64, 8'h0F);
    wr(8'h65, 8'h0F);
    perB <= 16'(n + d);
    settle(8'h00);
    perB <= 16'(n + d + 1);
    settle(8'h01);
    wr(8'h65, 8'h03);
    settle(8'h00);
    wr(8'h64, 8'h0C);
    wr(8'h65, 8'h0F);
    settle(8'h00);
    rd(8'h64, 8'h00);
    $display("test interrupt done");
    // Stop A dead and switch B off: late checks fire, B clears
    wr(8'h62, 8'h00);
    wr(8'h63, 8'h00);
    perA <= 16'h0000;
    settle(8'h01);
    check("live", {4'h0, failLive}, 8'h03);
    $display("test stop and disable done");
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
